// >>> orc_back_buffer.sv
// Purpose: Back-buffer memory model on the block's read port
// Assumes: One word in flight, answered slow+1 cycles after acceptance
// Notes  : Each word equals its byte address xor MARK
`timescale 1ns/10ps
module orc_back_buffer #(parameter logic [31:0] MARK = 32'h5a5a0001) (
  // Pacing and read port
  input  wire logic        clk, resetn, memReqValid,
  input  wire logic [3:0]  slow,
  input  wire logic [31:0] memReqAddr,
  output logic             memReqReady, memRspValid,
  output logic      [31:0] memRspData
);
  logic [4:0]  wait_q;
  logic [31:0] addr_q;
  // Accept, wait, answer; a released data line shows the inverse
  always @(posedge clk or negedge resetn)
    if (!resetn) {memReqReady, memRspValid, memRspData, wait_q} <= '0;
    else begin
      memReqReady <= memReqValid && !memReqReady && wait_q == 5'h0;
      memRspValid <= wait_q == 5'h1;
      if (wait_q == 5'h1) memRspData <= addr_q ^ MARK;
      else if (memRspValid) memRspData <= ~memRspData;
      if (memReqValid && memReqReady) addr_q <= memReqAddr;
      if (memReqValid && memReqReady) wait_q <= {1'b0, slow} + 5'h1;
      else if (wait_q != 5'h0) wait_q <= wait_q - 5'h1;
    end
endmodule // orc_back_buffer

// >>> orc_bank_mem.sv
// Purpose : Two-port register memory, one write port, one registered read
// Assumes : Write and read addresses in range
// Notes   : Read data appear one clock after the address
`timescale 1ns/10ps
module orc_bank_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 64
) (
  // Clock
  input  wire logic                     clk,
  // Write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("orc_bank_mem: unsupported size");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage write and registered read
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // orc_bank_mem

// >>> orc_pkg.sv
// Purpose : Shared constants and types of the overlay register update block
// Assumes : 20-bit byte offsets inside the overlay register window
// Notes   : Gamma reset values fall with offset, from c0c0c0 at the lowest offset to 080808 at the highest
package orc_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [19:0] OFF_UPDATE_ADDR = 20'h30000;
  localparam logic [19:0] OFF_TEST        = 20'h30004;
  localparam logic [19:0] OFF_STATUS      = 20'h30008;
  localparam logic [19:0] OFF_EXT_STATUS  = 20'h3000c;
  localparam logic [19:0] OFF_GAMMA       = 20'h30010;
  localparam logic [19:0] OFF_SYNC_PHASE  = 20'h30058;
  localparam logic [19:0] OFF_IMAGE       = 20'h30100;
  localparam logic [19:0] OFF_SCALE       = 20'h301a0;

  // ------------------------------------------------------------------
  // Counts and back-buffer layout
  // ------------------------------------------------------------------
  localparam int          GAMMA_COUNT     = 6;
  localparam int          SYNC_COUNT      = 4;
  localparam int          IMAGE_WORDS     = 30;
  localparam int          SCALE_WORDS     = 2;
  localparam int          CTRL_WORDS      = IMAGE_WORDS + SCALE_WORDS;
  localparam int          COEF_WORDS_DEF  = 256;
  localparam logic [31:0] BUF_SCALE_OFF   = 32'h000000a0;
  localparam logic [31:0] BUF_COEF_OFF    = 32'h00000200;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          UA_ADDR_LSB     = 12;
  localparam int          UA_COEF_BIT     = 0;
  localparam int          ST_UPDATE_BIT   = 31;
  localparam int          ST_ERR_BIT      = 17;
  localparam int          ST_HBLANK_BIT   = 14;
  localparam int          ST_VBLANK_BIT   = 12;
  localparam int          CMD_WORD        = 26;
  localparam int          CMD_ENABLE_BIT  = 0;
  localparam int          CMD_PIPE_BIT    = 18;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] UPDATE_ADDR_RST = 32'h00000000;
  localparam logic [31:0] TEST_RST        = 32'h00000000;
  localparam logic        UPD_STATUS_RST  = 1'b1;
  localparam logic [GAMMA_COUNT-1:0][23:0] GAMMA_RST = {
    24'h080808, 24'h101010, 24'h202020,
    24'h404040, 24'h808080, 24'hc0c0c0};

  // ------------------------------------------------------------------
  // Update sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ORC_IDLE = 2'b00,
    ORC_REQ  = 2'b01,
    ORC_RSP  = 2'b10,
    ORC_WAIT = 2'b11
  } orc_state_e;

endpackage

// >>> orc_tb.sv
// Purpose: Self-checking bench for the overlay register update block
// Assumes: Both pipes running except one phase with pipe 1 off, four coefficient words
// Notes  : Expected words are address xor the model's MARK
`timescale 1ns/10ps
module tb
  import orc_pkg::*;
;
  localparam logic [31:0] MARK = 32'h5a5a0001;
  logic clk = 1'b0, resetn = 1'b0, mmioRead = 1'b0, mmioWrite = 1'b0;
  logic flipValid = 1'b0, underrun = 1'b0, mmioRvalid, overlayOn, activePipe;
  logic memReqValid, memReqReady, memRspValid;
  logic [19:0] mmioAddr = '0;
  logic [31:0] mmioWdata = '0, flipData = '0, mmioRdata, memReqAddr;
  logic [31:0] memRspData, coefData;
  logic [1:0]  pipeVblank = '0, coefIndex = '0, pipeHblank = '0;
  logic [1:0]  pipeEnabled = 2'h3;
  logic [GAMMA_COUNT*24-1:0] gammaCurve;
  logic [3:0]  slow = '0;
  int          miscompares = 0, n_compared = 0;
  orc_update_ctrl #(.COEF_WORDS(4)) orc_update_ctrl_i (.clk, .resetn,
    .mmioRead, .mmioWrite, .mmioAddr, .mmioWdata, .mmioRdata, .mmioRvalid,
    .flipValid, .flipData, .memReqValid, .memReqAddr, .memReqReady,
    .memRspValid, .memRspData, .pipeVblank, .pipeHblank, .pipeEnabled,
    .underrun, .overlayOn, .activePipe, .coefIndex, .coefData, .gammaCurve);
  orc_back_buffer #(.MARK(MARK)) orc_back_buffer_i (.clk, .resetn, .slow,
    .memReqValid, .memReqAddr, .memReqReady, .memRspValid, .memRspData);
  initial forever #20 clk = ~clk;
  // Compare, access and timing helpers
  task automatic cmp(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic f, input logic [19:0] a, logic [31:0] d);
    @(posedge clk) {flipValid, mmioWrite, mmioAddr, mmioWdata} <= {f,!f,a,d};
    flipData <= d;
    @(posedge clk) {flipValid, mmioWrite} <= 2'h0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    @(posedge clk) {mmioRead, mmioAddr} <= {1'b1, a};
    @(posedge clk) mmioRead <= 1'b0;
    @(posedge clk) #1 cmp(mmioRvalid === 1'b1 ? mmioRdata : 32'hx, e);
  endtask
  task automatic blank(input int p);
    @(posedge clk) pipeVblank[p] <= 1'b1;
    repeat (3) @(posedge clk);
    pipeVblank[p] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic settle;
    int q = 0;
    for (int i = 0; i < 900 && q < 12; i++)
      @(posedge clk) q = (memReqValid === 1'b1) ? 0 : q + 1;
    cmp(32'(q), 32'd12);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_STATUS, 32'h80000000);
    rd(OFF_GAMMA, 32'h00c0c0c0);
    rd(OFF_EXT_STATUS, 32'h0);
    rd(OFF_TEST, 32'h0);
    pulse(0, OFF_TEST, 32'hffffffff);
    rd(OFF_TEST, 32'hffffffff);
    for (int g = 0; g < GAMMA_COUNT; g++) begin
      pulse(0, OFF_GAMMA + 20'(4 * g), 32'hff000000 | 32'(g * 32'h10203));
      rd(OFF_GAMMA + 20'(4 * g), 32'(g * 32'h10203));
    end
    cmp(32'(gammaCurve[143:120]), 32'h00050a0f);
    @(posedge clk) underrun <= 1'b1;
    @(posedge clk) underrun <= 1'b0;
    rd(OFF_STATUS, 32'h80020000);
    pulse(0, OFF_STATUS, 32'h00020000);
    rd(OFF_STATUS, 32'h80000000);
    $display("test registers done");
    pulse(1, OFF_UPDATE_ADDR, 32'h00010000);
    rd(OFF_STATUS, 32'h0);
    settle;
    blank(0);
    rd(OFF_STATUS, 32'h80000000);
    rd(OFF_IMAGE, 32'h00010000 ^ MARK);
    rd(OFF_SCALE + 20'h4, 32'h000100a4 ^ MARK);
    pulse(0, OFF_IMAGE, 32'h0);
    rd(OFF_IMAGE, 32'h00010000 ^ MARK);
    cmp({30'h0, overlayOn, activePipe}, 32'h2);
    $display("test flip done");
    slow <= 4'h3;
    pulse(0, OFF_UPDATE_ADDR, 32'h00020000);
    rd(OFF_STATUS, 32'h0);
    pulse(0, OFF_UPDATE_ADDR, 32'h00050000);
    settle;
    rd(OFF_IMAGE, 32'h00010000 ^ MARK);
    blank(0);
    cmp({30'h0, overlayOn, activePipe}, 32'h1);
    rd(OFF_STATUS, 32'h0);
    blank(1);
    cmp({30'h0, overlayOn, activePipe}, 32'h3);
    rd(OFF_STATUS, 32'h80000000);
    rd(OFF_IMAGE + 20'h4, 32'h00050004 ^ MARK);
    $display("test pipe switch done");
    pulse(1, OFF_UPDATE_ADDR, 32'h00060001);
    settle;
    blank(0);
    rd(OFF_STATUS, 32'h0);
    blank(1);
    rd(OFF_UPDATE_ADDR, 32'h00060001);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) coefIndex <= 2'(k);
      @(posedge clk) #1 cmp(coefData, (32'h00060200 + 32'(4 * k)) ^ MARK);
    end
    @(posedge clk) {pipeEnabled, pipeHblank} <= 4'h6;
    pulse(0, OFF_UPDATE_ADDR, 32'h00070000);
    settle;
    rd(OFF_STATUS, 32'h80004000);
    rd(OFF_IMAGE, 32'h00070000 ^ MARK);
    @(posedge clk) {pipeEnabled, pipeHblank} <= 4'hc;
    coefIndex <= 2'h0;
    @(posedge clk) #1 cmp(coefData, 32'h00060200 ^ MARK);
    rd(20'h30028, 32'h0);
    $display("test coefficients done");
    print_verdict;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule // tb

// >>> orc_update_ctrl.sv
// Purpose : Overlay register bank with double-buffered update from memory
// Assumes : MMIO, command stream, memory port and pipes share clk (25 MHz)
// Notes   : Staging bank is filled from memory, swapped in at vertical blank, or at once if the assigned pipe is off
`timescale 1ns/10ps

// What this block does
// - Update-address write clears update status, schedules load at next blank.
// - Load trigger is the leading edge of vertical blank including border, or at once if the assigned pipe is off.
// - Update status sets only after every register has been loaded.
// - Flip command starts the same update sequence as an address write.
// - A newer request before the load replaces the pending one.
// - Pipe-assign selects which pipe's blank triggers the load.
// - Pipe change disables at old pipe blank, enables at new pipe blank.
// - Loaded registers are double-buffered; updates may be requested anytime.
// - Double-buffered registers change only at their qualifying event.
// - Image registers read over MMIO, never written there.
// - On-chip registers except coefficients read at their map offsets; the sync phase words have no storage here and read zero.
// - Scaling words from base plus A0h/A4h, coefficients from base plus 200h.
// - Gamma breakpoints read and written directly over MMIO.
// - One access carries all three colour values of a breakpoint.
// - Update-address written by MMIO and by the flip command.
// - Read/clear bits set by hardware, cleared by writing a one.
// - Read-only bits follow hardware; reserved read-only bits read zero.
// - Firmware-reserved bits are plain storage without hardware effect.
// - Back-buffer address sits in bits 31:12, kept 4K aligned.
// - Address bit 0 set also loads the filter coefficients.
module orc_update_ctrl
  import orc_pkg::*;
#(
  parameter int COEF_WORDS = COEF_WORDS_DEF
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // MMIO register port
  input  wire logic                          mmioRead,
  input  wire logic                          mmioWrite,
  input  wire logic [19:0]                   mmioAddr,
  input  wire logic [31:0]                   mmioWdata,
  output logic      [31:0]                   mmioRdata,
  output logic                               mmioRvalid,
  // Command stream flip
  input  wire logic                          flipValid,
  input  wire logic [31:0]                   flipData,
  // Back-buffer memory read port
  output logic                               memReqValid,
  output logic      [31:0]                   memReqAddr,
  input  wire logic                          memReqReady,
  input  wire logic                          memRspValid,
  input  wire logic [31:0]                   memRspData,
  // Display pipe timing
  input  wire logic [1:0]                    pipeVblank,
  input  wire logic [1:0]                    pipeHblank,
  input  wire logic [1:0]                    pipeEnabled,
  input  wire logic                          underrun,
  // Overlay datapath side
  output logic                               overlayOn,
  output logic                               activePipe,
  input  wire logic [$clog2(COEF_WORDS)-1:0] coefIndex,
  output logic      [31:0]                   coefData,
  output logic      [GAMMA_COUNT*24-1:0]     gammaCurve
);

  initial begin
    if (COEF_WORDS < 2 || COEF_WORDS > 256
        || (COEF_WORDS & (COEF_WORDS - 1)) != 0) begin
      $error("orc_update_ctrl: COEF_WORDS must be a power of two, 2..256");
    end
  end

  localparam int CW  = $clog2(COEF_WORDS);
  localparam int IW  = $clog2(CTRL_WORDS + COEF_WORDS) + 1;
  localparam logic [IW-1:0] CTRL_LAST = IW'(CTRL_WORDS - 1);
  localparam logic [IW-1:0] ALL_LAST  = IW'(CTRL_WORDS + COEF_WORDS - 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  orc_state_e      state_q, state_d;
  logic [31:0]     updAddr_q;
  logic            reqNew_q;
  logic [31:0]     fetchBase_q, fetchBase_d;
  logic [IW-1:0]   fetchIdx_q, fetchIdx_d;
  logic            fetchCoef_q, fetchCoef_d;
  logic            activeBank_q;
  logic            coefBank_q;
  logic            stagedEnable_q;
  logic            stagedPipe_q;
  logic            switching_q;
  logic            pendEnable_q;
  logic            overlayOn_q;
  logic            activePipe_q;
  logic            updStatus_q;
  logic            ovErr_q;
  logic [31:0]     test_q;
  logic [GAMMA_COUNT-1:0][23:0] gamma_q;
  logic            memReqValid_q;
  logic [31:0]     memReqAddr_q;
  logic            rdPend_q;
  logic [19:0]     rdAddr_q;
  logic [31:0]     mmioRdata_q;
  logic            mmioRvalid_q;

  // ------------------------------------------------------------------
  // Blank edge detection
  // ------------------------------------------------------------------
  logic [1:0] vblLevel;
  logic [1:0] vblEdge;

  orc_vblank_edge #(
    .NPIPES      (2)
  ) u_vblank (
    .clk         (clk),
    .resetn      (resetn),
    .vblank      (pipeVblank),
    .vblankLevel (vblLevel),
    .vblankEdge  (vblEdge)
  );

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  wire        wrUpdAddr = mmioWrite && (mmioAddr == OFF_UPDATE_ADDR);
  wire        wrTest    = mmioWrite && (mmioAddr == OFF_TEST);
  wire        wrStatus  = mmioWrite && (mmioAddr == OFF_STATUS);
  wire        reqTaken  = flipValid || wrUpdAddr;
  wire [31:0] reqData   = flipValid ? flipData : mmioWdata;
  wire        rspTaken  = (state_q == ORC_RSP) && memRspValid;
  wire        fetchLast = fetchIdx_q == (fetchCoef_q ? ALL_LAST : CTRL_LAST);
  wire        inCtrl    = fetchIdx_q < IW'(CTRL_WORDS);

  // Load trigger: assigned pipe blank edge, or at once if that pipe is off
  wire trigger = vblEdge[activePipe_q] || !pipeEnabled[activePipe_q];
  wire commit  = (state_q == ORC_WAIT) && !reqNew_q && !switching_q
                 && trigger;
  wire pipeChg = commit && overlayOn_q && (stagedPipe_q != activePipe_q);
  wire swDone  = switching_q && trigger;
  wire updDone = (commit && !pipeChg) || swDone;

  // ------------------------------------------------------------------
  // Back-buffer address generation
  // ------------------------------------------------------------------
  logic [31:0] fetchAddr_d;
  logic [31:0] idxWord;

  always_comb begin
    idxWord = 32'(fetchIdx_d) << 2;
    if (fetchIdx_d < IW'(IMAGE_WORDS)) begin
      fetchAddr_d = fetchBase_d + idxWord;
    end else if (fetchIdx_d < IW'(CTRL_WORDS)) begin
      fetchAddr_d = fetchBase_d + BUF_SCALE_OFF
                    + idxWord - 32'(IMAGE_WORDS * 4);
    end else begin
      fetchAddr_d = fetchBase_d + BUF_COEF_OFF
                    + idxWord - 32'(CTRL_WORDS * 4);
    end
  end

  // ------------------------------------------------------------------
  // Update sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    fetchBase_d = fetchBase_q;
    fetchIdx_d  = fetchIdx_q;
    fetchCoef_d = fetchCoef_q;
    case (state_q)
      ORC_IDLE, ORC_WAIT: begin
        if (reqNew_q) begin
          state_d     = ORC_REQ;
          fetchBase_d = {updAddr_q[31:UA_ADDR_LSB], 12'h000};
          fetchCoef_d = updAddr_q[UA_COEF_BIT];
          fetchIdx_d  = '0;
        end else if (commit) begin
          state_d = ORC_IDLE;
        end
      end
      ORC_REQ: begin
        if (memReqReady) begin
          state_d = ORC_RSP;
        end
      end
      ORC_RSP: begin
        if (memRspValid) begin
          if (reqNew_q) begin
            state_d     = ORC_REQ;
            fetchBase_d = {updAddr_q[31:UA_ADDR_LSB], 12'h000};
            fetchCoef_d = updAddr_q[UA_COEF_BIT];
            fetchIdx_d  = '0;
          end else if (fetchLast) begin
            state_d = ORC_WAIT;
          end else begin
            state_d    = ORC_REQ;
            fetchIdx_d = fetchIdx_q + IW'(1);
          end
        end
      end
      default: begin
        state_d = ORC_IDLE;
      end
    endcase
  end

  // Sequencer registers and memory request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q       <= ORC_IDLE;
      fetchBase_q   <= 32'h00000000;
      fetchIdx_q    <= '0;
      fetchCoef_q   <= 1'b0;
      memReqValid_q <= 1'b0;
      memReqAddr_q  <= 32'h00000000;
    end else begin
      state_q       <= state_d;
      fetchBase_q   <= fetchBase_d;
      fetchIdx_q    <= fetchIdx_d;
      fetchCoef_q   <= fetchCoef_d;
      memReqValid_q <= (state_d == ORC_REQ);
      memReqAddr_q  <= fetchAddr_d;
    end
  end

  // Update address register and latest-request flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      updAddr_q <= UPDATE_ADDR_RST;
      reqNew_q  <= 1'b0;
    end else begin
      if (reqTaken) begin
        updAddr_q <= reqData;
      end
      if (reqTaken) begin
        reqNew_q <= 1'b1;
      end else if (state_d == ORC_REQ && fetchIdx_d == '0
                   && state_q != ORC_REQ) begin
        reqNew_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Staging and active banks
  // ------------------------------------------------------------------
  wire            ctrlWr    = rspTaken && inCtrl && !reqNew_q;
  wire            coefWr    = rspTaken && !inCtrl && !reqNew_q;
  wire [5:0]      ctrlWrA   = {~activeBank_q, fetchIdx_q[4:0]};
  wire [IW-1:0]   coefOff   = fetchIdx_q - IW'(CTRL_WORDS);
  wire [CW:0]     coefWrA   = {~coefBank_q, coefOff[CW-1:0]};
  wire [CW:0]     coefRdA   = {coefBank_q, coefIndex};
  wire            inImage   = (mmioAddr >= OFF_IMAGE)
                              && (mmioAddr < OFF_IMAGE + 20'(IMAGE_WORDS*4));
  wire            inScale   = (mmioAddr >= OFF_SCALE)
                              && (mmioAddr < OFF_SCALE + 20'(SCALE_WORDS*4));
  wire [19:0]     imgOff    = mmioAddr - OFF_IMAGE;
  wire [19:0]     sclOff    = mmioAddr - OFF_SCALE + 20'(IMAGE_WORDS*4);
  wire [4:0]      imgIdx    = inScale ? sclOff[6:2]
                              : inImage ? imgOff[6:2] : 5'h00;
  wire [5:0]      ctrlRdA   = {activeBank_q, imgIdx};
  logic [31:0]    ctrlRdData;

  // Control and scaling words, two banks
  orc_bank_mem #(
    .WIDTH  (32),
    .DEPTH  (2 * CTRL_WORDS)
  ) u_ctrl_mem (
    .clk    (clk),
    .wrEn   (ctrlWr),
    .wrAddr (ctrlWrA),
    .wrData (memRspData),
    .rdAddr (ctrlRdA),
    .rdData (ctrlRdData)
  );

  // Filter coefficients, two banks, read only by the scaler
  orc_bank_mem #(
    .WIDTH  (32),
    .DEPTH  (2 * COEF_WORDS)
  ) u_coef_mem (
    .clk    (clk),
    .wrEn   (coefWr),
    .wrAddr (coefWrA),
    .wrData (memRspData),
    .rdAddr (coefRdA),
    .rdData (coefData)
  );

  // Bank swap, enable and pipe assignment
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeBank_q   <= 1'b0;
      coefBank_q     <= 1'b0;
      stagedEnable_q <= 1'b0;
      stagedPipe_q   <= 1'b0;
      switching_q    <= 1'b0;
      pendEnable_q   <= 1'b0;
      overlayOn_q    <= 1'b0;
      activePipe_q   <= 1'b0;
    end else begin
      if (ctrlWr && fetchIdx_q == IW'(CMD_WORD)) begin
        stagedEnable_q <= memRspData[CMD_ENABLE_BIT];
        stagedPipe_q   <= memRspData[CMD_PIPE_BIT];
      end
      if (commit) begin
        activeBank_q <= ~activeBank_q;
        coefBank_q   <= coefBank_q ^ fetchCoef_q;
        activePipe_q <= stagedPipe_q;
        if (pipeChg) begin
          overlayOn_q  <= 1'b0;
          switching_q  <= 1'b1;
          pendEnable_q <= stagedEnable_q;
        end else begin
          overlayOn_q <= stagedEnable_q;
        end
      end else if (swDone) begin
        overlayOn_q <= pendEnable_q;
        switching_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status, test and gamma registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      updStatus_q <= UPD_STATUS_RST;
      ovErr_q     <= 1'b0;
      test_q      <= TEST_RST;
    end else begin
      if (reqTaken) begin
        updStatus_q <= 1'b0;
      end else if (updDone) begin
        updStatus_q <= 1'b1;
      end
      if (underrun) begin
        ovErr_q <= 1'b1;
      end else if (wrStatus && mmioWdata[ST_ERR_BIT]) begin
        ovErr_q <= 1'b0;
      end
      if (wrTest) begin
        test_q <= mmioWdata;
      end
    end
  end

  // Breakpoint registers, all three colours in one access
  for (genvar g = 0; g < GAMMA_COUNT; g++) begin : g_gamma
    wire hit = mmioWrite && (mmioAddr == OFF_GAMMA + 20'(g * 4));
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        gamma_q[g] <= GAMMA_RST[g];
      end else if (hit) begin
        gamma_q[g] <= mmioWdata[23:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path, answer two clocks after the request
  // ------------------------------------------------------------------
  wire [31:0] statusWord = {updStatus_q, 13'h0000, ovErr_q, 2'b00,
                            pipeHblank[activePipe_q], 1'b0,
                            vblLevel[activePipe_q], 12'h000};
  wire        rdGamma    = (rdAddr_q >= OFF_GAMMA)
                           && (rdAddr_q < OFF_GAMMA + 20'(GAMMA_COUNT*4));
  wire [19:0] gamOff     = rdAddr_q - OFF_GAMMA;
  wire [2:0]  gamIdx     = gamOff[4:2];
  wire        rdCtrl     = ((rdAddr_q >= OFF_IMAGE)
                           && (rdAddr_q < OFF_IMAGE + 20'(IMAGE_WORDS*4)))
                           || ((rdAddr_q >= OFF_SCALE)
                           && (rdAddr_q < OFF_SCALE + 20'(SCALE_WORDS*4)));

  // Register read select; unmapped, reserved and sync words read zero
  wire [31:0] rdMux = (rdAddr_q == OFF_UPDATE_ADDR) ? updAddr_q
                    : (rdAddr_q == OFF_TEST)        ? test_q
                    : (rdAddr_q == OFF_STATUS)      ? statusWord
                    : rdGamma ? {8'h00, gamma_q[gamIdx]}
                    : rdCtrl  ? ctrlRdData
                    : 32'h00000000;

  // Read pipeline
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdPend_q     <= 1'b0;
      rdAddr_q     <= 20'h00000;
      mmioRdata_q  <= 32'h00000000;
      mmioRvalid_q <= 1'b0;
    end else begin
      rdPend_q     <= mmioRead;
      if (mmioRead) begin
        rdAddr_q <= mmioAddr;
      end
      mmioRvalid_q <= rdPend_q;
      if (rdPend_q) begin
        mmioRdata_q <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign mmioRdata   = mmioRdata_q;
  assign mmioRvalid  = mmioRvalid_q;
  assign memReqValid = memReqValid_q;
  assign memReqAddr  = memReqAddr_q;
  assign overlayOn   = overlayOn_q;
  assign activePipe  = activePipe_q;
  assign gammaCurve  = gamma_q;

endmodule // orc_update_ctrl

// >>> orc_update_ctrl_checker.sv
// Purpose: Port assertions for the overlay register update block
// Assumes: One clock domain, resetn asynchronous active low
// Notes  : Attached by the bind statement after the module
`timescale 1ns/10ps
module orc_update_ctrl_checker
  import orc_pkg::*;
(
  // Watched ports of the block
  input wire logic        clk, resetn, mmioRead, mmioRvalid, memReqValid,
  input wire logic        memReqReady, overlayOn, activePipe,
  input wire logic [19:0] mmioAddr,
  input wire logic [31:0] mmioRdata, memReqAddr,
  input wire logic [1:0]  pipeVblank, pipeEnabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Memory word accepted by the far side
  sequence reqTaken;
    memReqValid && memReqReady;
  endsequence
  chk_read_lat: assert property (mmioRead |-> ##2 mmioRvalid)
    else $error("read answer late");
  chk_ans_cause: assert property (mmioRvalid |-> $past(mmioRead, 2))
    else $error("answer without read");
  chk_rdata_hold: assert property (!mmioRvalid |-> $stable(mmioRdata))
    else $error("read data moved");
  chk_status_resv: assert property (
    mmioRead && mmioAddr == OFF_STATUS |-> ##2 (mmioRdata & 32'h7ffdafff) == 0)
    else $error("reserved status bit set");
  chk_req_held: assert property (memReqValid && !memReqReady
    |=> memReqValid && $stable(memReqAddr)) else $error("request dropped");
  chk_one_out: assert property (reqTaken |=> !memReqValid)
    else $error("second request outstanding");
  chk_word_align: assert property (memReqValid |-> memReqAddr[1:0] == 0)
    else $error("request not word aligned");
  chk_blank_only: assert property (
    (pipeVblank == 2'h0 && pipeEnabled == 2'h3) [*4]
    |=> $stable({overlayOn, activePipe})) else $error("commit without blank");
endmodule // orc_update_ctrl_checker

bind orc_update_ctrl orc_update_ctrl_checker orc_update_ctrl_checker_i (
  .clk, .resetn, .mmioRead, .mmioRvalid, .memReqValid, .memReqReady,
  .overlayOn, .activePipe, .mmioAddr, .mmioRdata, .memReqAddr, .pipeVblank,
  .pipeEnabled);

// >>> orc_vblank_edge.sv
// Purpose : Leading-edge detection of vertical blank for each display pipe
// Assumes : Blank levels come from timing generators on the same clock
// Notes   : Blank level already includes the vertical border
`timescale 1ns/10ps
module orc_vblank_edge #(
  parameter int NPIPES = 2
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Blank levels from the pipes
  input  wire logic [NPIPES-1:0] vblank,
  // Registered level and one-cycle edge
  output logic      [NPIPES-1:0] vblankLevel,
  output logic      [NPIPES-1:0] vblankEdge
);

  initial begin
    if (NPIPES < 1) begin
      $error("orc_vblank_edge: NPIPES must be at least one");
    end
  end

  // Per-pipe edge detector
  for (genvar p = 0; p < NPIPES; p++) begin : g_pipe
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        vblankLevel[p] <= 1'b0;
        vblankEdge[p]  <= 1'b0;
      end else begin
        vblankLevel[p] <= vblank[p];
        vblankEdge[p]  <= vblank[p] & ~vblankLevel[p];
      end
    end
  end

endmodule // orc_vblank_edge
